// ==== sdram_bank_map.svh ====
// Constants for the bank command legality block: command codes, timings, field positions.
// Assumes a 10 MHz core clock; times are given in ns and turned into cycle counts.
`ifndef SDRAM_BANK_MAP_SVH
`define SDRAM_BANK_MAP_SVH

`define CLK_PERIOD_NS        100
`define PRECHARGE_PERIOD_NS  20
`define WRITE_RECOVERY_NS    15
`define ROW_TO_COLUMN_NS     20
`define SELF_REF_EXIT_NS     120
// Least times round up, at least one cycle
`define CYC_UP(ns)           (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_CYC        `CYC_UP(`PRECHARGE_PERIOD_NS)
`define WRITE_RECOVERY_CYC   `CYC_UP(`WRITE_RECOVERY_NS)
`define ROW_TO_COLUMN_CYC    `CYC_UP(`ROW_TO_COLUMN_NS)
`define SELF_REF_EXIT_CYC    `CYC_UP(`SELF_REF_EXIT_NS)

// Command strobe codes {ras_n, cas_n, we_n}
`define CMD_NOP        3'h7
`define CMD_ACTIVE     3'h3
`define CMD_READ       3'h5
`define CMD_WRITE      3'h4
`define CMD_BTERM      3'h6
`define CMD_PRECHARGE  3'h2
`define CMD_REFRESH    3'h1
`define CMD_LOADMODE   3'h0

// Address bit that carries auto precharge / all-bank precharge
`define AP_BIT         10
`define TIMER_W        4
`define NUM_BANKS      4
`define DEFAULT_CL     2
`define DEFAULT_BL     4

`endif

// ==== sdram_bank_pkg.sv ====
// Types shared by the bank command legality block.
// Assumes sdram_bank_map.svh supplies the numeric constants.
package sdram_bank_pkg;

   typedef enum logic [3:0] {
      BANK_IDLE,
      BANK_ACTIVATING,
      BANK_ACTIVE,
      BANK_READ,
      BANK_WRITE,
      BANK_READ_AP,
      BANK_WRITE_AP,
      BANK_PRECHARGING
   } bank_state_e;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_ACTIVE,
      OP_READ,
      OP_WRITE,
      OP_BTERM,
      OP_PRECHARGE,
      OP_ALL_BANK
   } op_e;

   typedef struct packed {
      logic       cs_n;
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
      logic [1:0] bank;
      logic       ap;
   } cmd_s;

   typedef struct packed {
      op_e        op;
      logic [1:0] bank;
      logic       ap;
      logic       precharge_all;
   } decoded_s;

endpackage : sdram_bank_pkg

// ==== sdram_bank_fsm.sv ====
// One bank's state machine: activation, bursts, auto precharge and precharge timing.
// Assumes the decoded command and interrupt flags come from the same clock domain.
`timescale 1ns/1ps
`include "sdram_bank_map.svh"

module sdram_bank_fsm #(
   parameter int BL = `DEFAULT_BL
) (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic                       enable,
   input  wire sdram_bank_pkg::decoded_s   cmd,
   input  wire logic                       cmd_valid,
   input  wire logic                       is_mine,
   input  wire logic                       other_burst,
   input  wire logic                       stop_burst,
   output sdram_bank_pkg::bank_state_e     state,
   output logic                            burst_active
);
   logic [`TIMER_W-1:0] timer;
   logic [7:0]          beats;
   logic                ap_pending;

   initial begin
      if (BL < 1 || BL > 255) $error("sdram_bank_fsm: BL out of range");
   end

   assign burst_active = (state == sdram_bank_pkg::BANK_READ) || (state == sdram_bank_pkg::BANK_WRITE)
                      || (((state == sdram_bank_pkg::BANK_READ_AP) || (state == sdram_bank_pkg::BANK_WRITE_AP))
                          && !ap_pending);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state      <= sdram_bank_pkg::BANK_IDLE;
         timer      <= '0;
         beats      <= '0;
         ap_pending <= 1'b0;
      end else if (enable) begin
         if (timer != '0)
            timer <= timer - 1'b1;
         if (beats != '0)
            beats <= beats - 8'h01;
         case (state)
            sdram_bank_pkg::BANK_IDLE: begin
               if (cmd_valid && is_mine && cmd.op == sdram_bank_pkg::OP_ACTIVE) begin
                  state <= sdram_bank_pkg::BANK_ACTIVATING;
                  timer <= `TIMER_W'(`ROW_TO_COLUMN_CYC - 1);
               end
            end
            sdram_bank_pkg::BANK_ACTIVATING: begin
               if (timer == '0)
                  state <= sdram_bank_pkg::BANK_ACTIVE;
            end
            sdram_bank_pkg::BANK_PRECHARGING: begin
               if (timer == '0)
                  state <= sdram_bank_pkg::BANK_IDLE;
            end
            sdram_bank_pkg::BANK_READ_AP, sdram_bank_pkg::BANK_WRITE_AP: begin
               if (ap_pending) begin
                  if (timer == '0) begin
                     state      <= sdram_bank_pkg::BANK_PRECHARGING;
                     timer      <= `TIMER_W'(`PRECHARGE_CYC - 1);
                     ap_pending <= 1'b0;
                  end
               end else if (other_burst || stop_burst || beats == 8'h01) begin
                  // Concurrent auto precharge once the burst is cut or ends
                  ap_pending <= 1'b1;
                  if (state == sdram_bank_pkg::BANK_WRITE_AP)
                     timer <= `TIMER_W'(`WRITE_RECOVERY_CYC - 1);
                  else begin
                     state      <= sdram_bank_pkg::BANK_PRECHARGING;
                     timer      <= `TIMER_W'(`PRECHARGE_CYC - 1);
                     ap_pending <= 1'b0;
                  end
               end
            end
            default: begin
               // Active, read or write without auto precharge
               if (cmd_valid && is_mine && cmd.op == sdram_bank_pkg::OP_PRECHARGE) begin
                  state <= sdram_bank_pkg::BANK_PRECHARGING;
                  timer <= `TIMER_W'(`PRECHARGE_CYC - 1);
               end else if (cmd_valid && is_mine
                            && (cmd.op == sdram_bank_pkg::OP_READ || cmd.op == sdram_bank_pkg::OP_WRITE)) begin
                  // New column restarts the burst
                  beats <= 8'(BL);
                  if (cmd.op == sdram_bank_pkg::OP_READ)
                     state <= cmd.ap ? sdram_bank_pkg::BANK_READ_AP : sdram_bank_pkg::BANK_READ;
                  else
                     state <= cmd.ap ? sdram_bank_pkg::BANK_WRITE_AP : sdram_bank_pkg::BANK_WRITE;
               end else if ((state == sdram_bank_pkg::BANK_READ || state == sdram_bank_pkg::BANK_WRITE)
                            && (other_burst || stop_burst || beats == 8'h01)) begin
                  state <= sdram_bank_pkg::BANK_ACTIVE;
               end
            end
         endcase
      end
   end
endmodule : sdram_bank_fsm

// ==== sdram_bank_legality.sv ====
// Top of the bank command legality block: samples command pins, tracks banks,
// flags illegal commands and reports data bus ownership.
// Assumes pins come from outside the clock domain and are resynchronised here.
`timescale 1ns/1ps
`include "sdram_bank_map.svh"

module sdram_bank_legality #(
   parameter int NBANK = `NUM_BANKS,
   parameter int CL    = `DEFAULT_CL,
   parameter int BL    = `DEFAULT_BL
) (
   input  wire logic        CLOCK,
   input  wire logic        RSTN,
   input  wire logic        CS_N,
   input  wire logic        RAS_N,
   input  wire logic        CAS_N,
   input  wire logic        WE_N,
   input  wire logic        CKE,
   input  wire logic [1:0]  BANK_ADDR,
   input  wire logic        AUTO_PRECHARGE,
   input  wire logic        DATA_MASK,
   input  wire logic        SELF_REFRESH_EXIT,
   output logic             ILLEGAL_CMD,
   output logic             READ_DATA_DRIVE,
   output logic             WRITE_DATA_TAKE,
   output logic [1:0]       DATA_BANK,
   output logic [3:0]       BANK_IDLE
);

   initial begin
      if (NBANK != 4) $error("sdram_bank_legality: only four banks supported");
      if (CL < 1 || CL > 8) $error("sdram_bank_legality: CL out of range");
   end

   // Two-stage synchronisers for pin inputs
   sdram_bank_pkg::cmd_s   cmd_meta;
   sdram_bank_pkg::cmd_s   cmd_pin;
   logic [2:0]             lvl_meta;
   logic [2:0]             lvl_pin;
   logic                   cke_prev;

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         cmd_meta <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, bank: 2'h0, ap: 1'b0};
         cmd_pin  <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, bank: 2'h0, ap: 1'b0};
         lvl_meta <= 3'h0;
         lvl_pin  <= 3'h0;
      end else begin
         cmd_meta <= '{cs_n: CS_N, ras_n: RAS_N, cas_n: CAS_N, we_n: WE_N, bank: BANK_ADDR, ap: AUTO_PRECHARGE};
         cmd_pin  <= cmd_meta;
         lvl_meta <= {CKE, DATA_MASK, SELF_REFRESH_EXIT};
         lvl_pin  <= lvl_meta;
      end
   end

   wire cke_now  = lvl_pin[2];
   wire mask_now = lvl_pin[1];
   wire sr_exit  = lvl_pin[0];

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN)
         cke_prev <= 1'b0;
      else
         cke_prev <= cke_now;
   end

   // Self-refresh exit wait
   logic [7:0] xsr_count;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN)
         xsr_count <= 8'h00;
      else if (sr_exit)
         xsr_count <= 8'(`SELF_REF_EXIT_CYC);
      else if (xsr_count != 8'h00)
         xsr_count <= xsr_count - 8'h01;
   end

   wire rules_on = cke_prev && cke_now && (xsr_count == 8'h00);

   // Command decode
   sdram_bank_pkg::decoded_s dec;
   logic                     dec_valid;
   always_comb begin
      dec.bank          = cmd_pin.bank;
      dec.ap            = cmd_pin.ap;
      dec.precharge_all = 1'b0;
      dec.op            = sdram_bank_pkg::OP_NONE;
      dec_valid         = 1'b0;
      if (!cmd_pin.cs_n && rules_on) begin
         dec_valid = 1'b1;
         case ({cmd_pin.ras_n, cmd_pin.cas_n, cmd_pin.we_n})
            `CMD_ACTIVE:    dec.op = sdram_bank_pkg::OP_ACTIVE;
            `CMD_READ:      dec.op = sdram_bank_pkg::OP_READ;
            `CMD_WRITE:     dec.op = sdram_bank_pkg::OP_WRITE;
            `CMD_BTERM:     dec.op = sdram_bank_pkg::OP_BTERM;
            `CMD_PRECHARGE: begin
               dec.op            = sdram_bank_pkg::OP_PRECHARGE;
               dec.precharge_all = cmd_pin.ap;
            end
            `CMD_REFRESH, `CMD_LOADMODE: dec.op = sdram_bank_pkg::OP_ALL_BANK;
            default:        dec.op = sdram_bank_pkg::OP_NONE;
         endcase
      end
   end

   wire is_burst = dec_valid && (dec.op == sdram_bank_pkg::OP_READ || dec.op == sdram_bank_pkg::OP_WRITE);

   // Most recent burst owner, for burst terminate
   logic [1:0] last_bank;
   logic       last_is_read;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         last_bank    <= 2'h0;
         last_is_read <= 1'b0;
      end else if (is_burst) begin
         last_bank    <= dec.bank;
         last_is_read <= (dec.op == sdram_bank_pkg::OP_READ);
      end
   end

   sdram_bank_pkg::bank_state_e bstate [4];
   logic [3:0]                  bursting;

   for (genvar b = 0; b < 4; b++) begin : g_bank
      wire mine        = (dec.bank == 2'(b)) || (dec.op == sdram_bank_pkg::OP_PRECHARGE && dec.precharge_all);
      // Another bank's burst cuts this one; precharge to others does not
      wire other_burst = is_burst && (dec.bank != 2'(b));
      wire stop        = dec_valid && dec.op == sdram_bank_pkg::OP_BTERM && last_bank == 2'(b);
      sdram_bank_fsm #(
         .BL (BL)
      ) u_fsm (
         .clk          (CLOCK),
         .rstn         (RSTN),
         .enable       (cke_now),
         .cmd          (dec),
         .cmd_valid    (dec_valid),
         .is_mine      (mine),
         .other_burst  (other_burst),
         .stop_burst   (stop),
         .state        (bstate[b]),
         .burst_active (bursting[b])
      );
   end

   // Legality check against the addressed bank; all banks for refresh and load mode, the last burst bank for burst terminate
   logic all_idle;
   logic legal;
   sdram_bank_pkg::bank_state_e tgt;
   always_comb begin
      all_idle = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (bstate[i] != sdram_bank_pkg::BANK_IDLE)
            all_idle = 1'b0;
      end
      tgt   = bstate[dec.bank];
      legal = 1'b1;
      case (dec.op)
         sdram_bank_pkg::OP_ALL_BANK:
            legal = all_idle;
         sdram_bank_pkg::OP_ACTIVE:
            legal = (tgt == sdram_bank_pkg::BANK_IDLE);
         sdram_bank_pkg::OP_READ, sdram_bank_pkg::OP_WRITE:
            legal = (tgt == sdram_bank_pkg::BANK_ACTIVE) || (tgt == sdram_bank_pkg::BANK_READ)
                 || (tgt == sdram_bank_pkg::BANK_WRITE);
         sdram_bank_pkg::OP_PRECHARGE:
            legal = dec.precharge_all
                 || !(tgt == sdram_bank_pkg::BANK_ACTIVATING || tgt == sdram_bank_pkg::BANK_READ_AP
                      || tgt == sdram_bank_pkg::BANK_WRITE_AP);
         sdram_bank_pkg::OP_BTERM:
            legal = bursting[last_bank];
         default:
            legal = 1'b1;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN)
         ILLEGAL_CMD <= 1'b0;
      else
         ILLEGAL_CMD <= dec_valid && !legal;
   end

   // Read data pipeline, eight deep, tapped at the column latency
   logic [7:0] rd_pipe;
   logic [1:0] rd_bank_pipe [8];
   logic [7:0] rd_beats;
   logic [1:0] rd_bank;
   logic       rd_go;
   logic       wr_go;
   logic [7:0] wr_beats;
   logic [1:0] wr_bank;

   assign rd_go = dec_valid && legal && dec.op == sdram_bank_pkg::OP_READ;
   assign wr_go = dec_valid && legal && dec.op == sdram_bank_pkg::OP_WRITE;
   wire   term  = dec_valid && dec.op == sdram_bank_pkg::OP_BTERM;
   // Precharge to the bank of the latest burst truncates its data
   wire   pre_cut = dec_valid && legal && dec.op == sdram_bank_pkg::OP_PRECHARGE
                    && (dec.precharge_all || dec.bank == last_bank);

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rd_pipe <= 8'h00;
         for (int i = 0; i < 8; i++)
            rd_bank_pipe[i] <= 2'h0;
      end else begin
         rd_pipe         <= {rd_pipe[6:0], rd_go};
         rd_bank_pipe[0] <= dec.bank;
         for (int i = 1; i < 8; i++)
            rd_bank_pipe[i] <= rd_bank_pipe[i-1];
      end
   end

   wire rd_arrive = rd_pipe[CL-1];

   // Read drive counter: a new read takes the bus CL later
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rd_beats <= 8'h00;
         rd_bank  <= 2'h0;
      end else if (wr_go) begin
         rd_beats <= 8'h00;
      end else if (rd_arrive) begin
         rd_beats <= 8'(BL);
         rd_bank  <= rd_bank_pipe[CL-1];
      end else if ((term || pre_cut) && last_is_read) begin
         rd_beats <= 8'h00;
      end else if (rd_beats != 8'h00) begin
         rd_beats <= rd_beats - 8'h01;
      end
   end

   // Write data acceptance: cut at once by any new command burst
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN)
         wr_beats <= 8'h00;
      else if (wr_go)
         wr_beats <= 8'(BL - 1);
      else if (rd_go || ((term || pre_cut) && !last_is_read))
         wr_beats <= 8'h00;
      else if (wr_beats != 8'h00)
         wr_beats <= wr_beats - 8'h01;
   end

   // Bank of the write burst that owns the bus
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN)
         wr_bank <= 2'h0;
      else if (wr_go)
         wr_bank <= dec.bank;
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         READ_DATA_DRIVE <= 1'b0;
         WRITE_DATA_TAKE <= 1'b0;
         DATA_BANK       <= 2'h0;
      end else begin
         READ_DATA_DRIVE <= (rd_arrive || (rd_beats > 8'h01)) && !wr_go && !mask_now;
         WRITE_DATA_TAKE <= (wr_go || wr_beats != 8'h00) && !rd_go && !mask_now;
         DATA_BANK       <= wr_go ? dec.bank
                          : (rd_arrive ? rd_bank_pipe[CL-1] : ((wr_beats != 8'h00) ? wr_bank : rd_bank));
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN)
         BANK_IDLE <= 4'hf;
      else
         for (int i = 0; i < 4; i++)
            BANK_IDLE[i] <= (bstate[i] == sdram_bank_pkg::BANK_IDLE);
   end

endmodule : sdram_bank_legality

// ==== sdram_bank_legality_checker.sv ====
// Checker for the bank command legality block: flag timing against command pins.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/1ps
`include "sdram_bank_map.svh"

module sdram_bank_legality_checker #(
   parameter int NBANK = `NUM_BANKS,
   parameter int CL    = `DEFAULT_CL,
   parameter int BL    = `DEFAULT_BL
) (
   input wire logic       CLOCK,
   input wire logic       RSTN,
   input wire logic       CS_N,
   input wire logic       RAS_N,
   input wire logic       CAS_N,
   input wire logic       WE_N,
   input wire logic       CKE,
   input wire logic [1:0] BANK_ADDR,
   input wire logic       AUTO_PRECHARGE,
   input wire logic       DATA_MASK,
   input wire logic       SELF_REFRESH_EXIT,
   input wire logic       ILLEGAL_CMD,
   input wire logic       READ_DATA_DRIVE,
   input wire logic       WRITE_DATA_TAKE,
   input wire logic [1:0] DATA_BANK,
   input wire logic [3:0] BANK_IDLE
);
   logic [3:0] act_hist;
   logic [1:0] pre_bank;
   logic       cke_prev;
   wire  [2:0] op   = {RAS_N, CAS_N, WE_N};
   wire        live = !CS_N && CKE && cke_prev;

   // Recent activates and last precharged bank
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         act_hist <= 4'h0;
         pre_bank <= 2'h0;
         cke_prev <= 1'b0;
      end else begin
         act_hist <= {act_hist[2:0], live && op == `CMD_ACTIVE};
         cke_prev <= CKE;
         if (live && op == `CMD_PRECHARGE) begin
            pre_bank <= BANK_ADDR;
         end
      end
   end

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RSTN);

   property p_inhibit;
      CS_N |-> ##3 !ILLEGAL_CMD;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("illegal flag after deselect");
   property p_cke_off;
      !CKE |-> ##3 !ILLEGAL_CMD;
   endproperty
   a_cke_off: assert property (p_cke_off) else $error("command seen with clock enable low");
   property p_one_owner;
      !(READ_DATA_DRIVE && WRITE_DATA_TAKE);
   endproperty
   a_one_owner: assert property (p_one_owner) else $error("read and write own bus together");
   property p_read_beat;
      (live && op == `CMD_READ && !BANK_IDLE[BANK_ADDR] && !DATA_MASK) ##1 !DATA_MASK [*4]
         |=> READ_DATA_DRIVE && DATA_BANK == $past(BANK_ADDR, 5);
   endproperty
   a_read_beat: assert property (p_read_beat) else $error("read data late or wrong bank");
   property p_write_beat;
      (live && op == `CMD_WRITE && !BANK_IDLE[BANK_ADDR] && !DATA_MASK) ##1 !DATA_MASK [*2]
         |=> WRITE_DATA_TAKE && DATA_BANK == $past(BANK_ADDR, 3);
   endproperty
   a_write_beat: assert property (p_write_beat) else $error("write take late or wrong bank");
   property p_read_idle;
      live && op == `CMD_READ && BANK_IDLE[BANK_ADDR] && act_hist == 4'h0 |-> ##3 ILLEGAL_CMD;
   endproperty
   a_read_idle: assert property (p_read_idle) else $error("read to idle bank not flagged");
   property p_refresh_busy;
      live && (op == `CMD_REFRESH || op == `CMD_LOADMODE) && !(&BANK_IDLE) |-> ##3 ILLEGAL_CMD;
   endproperty
   a_refresh_busy: assert property (p_refresh_busy) else $error("refresh with open bank");
   property p_pre_idle;
      live && op == `CMD_PRECHARGE && !AUTO_PRECHARGE |=> ##[2:10] BANK_IDLE[pre_bank];
   endproperty
   a_pre_idle: assert property (p_pre_idle) else $error("precharged bank not idle");
   property p_pre_all;
      live && op == `CMD_PRECHARGE && AUTO_PRECHARGE |-> ##[3:12] &BANK_IDLE;
   endproperty
   a_pre_all: assert property (p_pre_all) else $error("banks not idle after precharge all");

   c_bank_swap: cover property (READ_DATA_DRIVE && $changed(DATA_BANK));
   c_read_to_write: cover property ($fell(READ_DATA_DRIVE) ##[1:4] WRITE_DATA_TAKE);
   c_illegal: cover property (ILLEGAL_CMD);
endmodule : sdram_bank_legality_checker

bind sdram_bank_legality sdram_bank_legality_checker #(.NBANK(NBANK), .CL(CL), .BL(BL)) u_checker (
   .CLOCK(CLOCK), .RSTN(RSTN), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N),
   .CKE(CKE), .BANK_ADDR(BANK_ADDR), .AUTO_PRECHARGE(AUTO_PRECHARGE), .DATA_MASK(DATA_MASK),
   .SELF_REFRESH_EXIT(SELF_REFRESH_EXIT), .ILLEGAL_CMD(ILLEGAL_CMD), .READ_DATA_DRIVE(READ_DATA_DRIVE),
   .WRITE_DATA_TAKE(WRITE_DATA_TAKE), .DATA_BANK(DATA_BANK), .BANK_IDLE(BANK_IDLE));

// ==== sdram_ctrl_model.sv ====
// Memory controller model: command strobes, clock enable, data mask, exit pulse.
// Assumes the bench calls its tasks; pins change on the falling clock edge.
`timescale 1ns/1ps

module sdram_ctrl_model (
   input  wire logic            clk,
   output sdram_bank_pkg::cmd_s pins,
   output logic                 cke,
   output logic                 dm,
   output logic                 srx
);
   initial begin
      pins = 7'h7f;
      cke  = 1'b1;
      dm   = 1'b0;
      srx  = 1'b0;
   end

   // Command, then gap deselected cycles with toggling strobes
   task automatic send(input sdram_bank_pkg::cmd_s c, input int gap);
      @(negedge clk);
      pins = c;
      dm   = 1'b0;
      repeat (gap) begin
         @(negedge clk);
         pins = {1'b1, ~pins[5:0]};
      end
   endtask : send

   // Mask raised two clocks ahead of a write
   task automatic masked_write(input sdram_bank_pkg::cmd_s c, input int gap);
      @(negedge clk);
      dm   = 1'b1;
      pins = {1'b1, ~pins[5:0]};
      @(negedge clk);
      pins = {1'b1, ~pins[5:0]};
      send(c, gap);
   endtask : masked_write

   task automatic set_cke(input logic v);
      @(negedge clk);
      cke = v;
   endtask : set_cke

   task automatic exit_pulse();
      @(negedge clk);
      srx = 1'b1;
      @(negedge clk);
      srx = 1'b0;
   endtask : exit_pulse
endmodule : sdram_ctrl_model

// ==== sdram_bank_legality_tb.sv ====
// Testbench for the bank command legality block: scripted commands after random strobes with the chip deselected.
// Assumes the default timings, CL and BL of the design package and map header.
`timescale 1ns/1ps
`include "sdram_bank_map.svh"

module sdram_bank_legality_tb;
   localparam logic [1:0] RD = 2'h1;
   localparam logic [1:0] WR = 2'h2;
   localparam logic [1:0] IL = 2'h3;
   logic                 clock;
   logic                 rstn;
   sdram_bank_pkg::cmd_s pins;
   logic                 cke, dm, srx, illegal, rd, wr, prev_rd, prev_wr;
   logic [1:0]           dbank, prev_bank;
   logic [3:0]           idle;
   logic [3:0]           expq[$];
   logic [31:0]          rng = 32'hbc03;
   int                   miscompares = 0;
   int                   cmp_count = 0;
   int                   beats = 0;

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   sdram_ctrl_model u_ctrl (.clk(clock), .pins(pins), .cke(cke), .dm(dm), .srx(srx));

   sdram_bank_legality u_dut (
      .CLOCK(clock), .RSTN(rstn), .CS_N(pins.cs_n), .RAS_N(pins.ras_n), .CAS_N(pins.cas_n),
      .WE_N(pins.we_n), .CKE(cke), .BANK_ADDR(pins.bank), .AUTO_PRECHARGE(pins.ap), .DATA_MASK(dm),
      .SELF_REFRESH_EXIT(srx), .ILLEGAL_CMD(illegal), .READ_DATA_DRIVE(rd), .WRITE_DATA_TAKE(wr),
      .DATA_BANK(dbank), .BANK_IDLE(idle));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic take(input logic [3:0] seen);
      logic [3:0] exp;
      exp = (expq.size() > 0) ? expq.pop_front() : 4'hf;
      check({4'h0, seen}, {4'h0, exp});
   endtask : take

   task automatic go(input logic [2:0] op, input logic [1:0] b, input logic ap, input int gap,
                     input logic [1:0] kind);
      if (kind != 2'h0) expq.push_back({kind, (kind == IL) ? 2'h0 : b});
      u_ctrl.send({1'b0, op, b, ap}, gap);
   endtask : go

   task automatic wait_idle(input logic [3:0] exp);
      int n;
      n = 0;
      while (idle !== exp && n < 24) begin
         @(negedge clock);
         n++;
      end
      check({4'h0, idle}, {4'h0, exp});
   endtask : wait_idle

   // Result watcher: burst starts, bus hand-overs and illegal flags
   always @(negedge clock) begin
      if (rstn) begin
         if (illegal === 1'b1) take({IL, 2'h0});
         if (rd === 1'b1 && (!prev_rd || dbank !== prev_bank)) take({RD, dbank});
         if (wr === 1'b1 && (!prev_wr || dbank !== prev_bank)) take({WR, dbank});
         if (rd === 1'b1) beats++;
      end
      prev_rd = rd;
      prev_wr = wr;
      prev_bank = dbank;
   end

   task automatic conclude();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   // About fifteen times the scripted run
   initial begin
      #300000;
      miscompares++;
      conclude();
   end

   initial begin
      int start;
      rstn = 1'b0;
      repeat (4) @(negedge clock);
      rstn = 1'b1;
      check({4'h0, idle}, 8'h0f);
      check({3'h0, illegal, rd, wr, dbank}, 8'h00);
      repeat (16) begin
         rng = xs(rng);
         u_ctrl.send({1'b1, rng[5:0]}, 0);
      end
      go(`CMD_READ, rng[1:0], 1'b0, 4, IL);
      go(`CMD_ACTIVE, 2'h0, 1'b0, 4, 2'h0);
      go(`CMD_REFRESH, 2'h0, 1'b0, 4, IL);
      go(`CMD_LOADMODE, 2'h0, 1'b0, 4, IL);
      go(`CMD_ACTIVE, 2'h1, 1'b0, 4, 2'h0);
      go(`CMD_READ, 2'h0, 1'b0, 2, RD);
      go(`CMD_READ, 2'h1, 1'b0, 8, RD);
      go(`CMD_READ, 2'h0, 1'b0, 2, RD);
      go(`CMD_BTERM, 2'h0, 1'b0, 8, 2'h0);
      go(`CMD_READ, 2'h0, 1'b0, 5, RD);
      go(`CMD_PRECHARGE, 2'h0, 1'b0, 2, 2'h0);
      wait_idle(4'hd);
      go(`CMD_ACTIVE, 2'h0, 1'b0, 4, 2'h0);
      go(`CMD_WRITE, 2'h0, 1'b0, 1, WR);
      go(`CMD_PRECHARGE, 2'h0, 1'b0, 2, 2'h0);
      wait_idle(4'hd);
      go(`CMD_ACTIVE, 2'h2, 1'b0, 4, 2'h0);
      go(`CMD_READ, 2'h1, 1'b0, 4, RD);
      expq.push_back({WR, 2'h2});
      u_ctrl.masked_write({1'b0, `CMD_WRITE, 2'h2, 1'b0}, 8);
      go(`CMD_WRITE, 2'h2, 1'b1, 2, WR);
      go(`CMD_READ, 2'h1, 1'b0, 8, RD);
      wait_idle(4'hd);
      go(`CMD_ACTIVE, 2'h0, 1'b0, 4, 2'h0);
      go(`CMD_WRITE, 2'h0, 1'b0, 2, WR);
      go(`CMD_WRITE, 2'h1, 1'b0, 8, WR);
      go(`CMD_READ, 2'h1, 1'b1, 2, RD);
      go(`CMD_READ, 2'h0, 1'b0, 8, RD);
      wait_idle(4'he);
      go(`CMD_NOP, 2'h0, 1'b0, 4, 2'h0);
      start = beats;
      go(`CMD_READ, 2'h0, 1'b0, 0, RD);
      go(`CMD_PRECHARGE, 2'h3, 1'b0, 10, 2'h0);
      check(8'(beats - start), 8'(`DEFAULT_BL));
      u_ctrl.set_cke(1'b0);
      go(`CMD_READ, 2'h3, 1'b0, 4, 2'h0);
      u_ctrl.set_cke(1'b1);
      u_ctrl.exit_pulse();
      go(`CMD_NOP, 2'h0, 1'b0, 6, 2'h0);
      go(`CMD_READ, 2'h3, 1'b0, 4, IL);
      go(`CMD_PRECHARGE, 2'h0, 1'b1, 8, 2'h0);
      wait_idle(4'hf);
      check(8'(expq.size()), 8'h00);
      conclude();
   end
endmodule : sdram_bank_legality_tb
